// >>> hw/tcu8_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "tcu8_regs.vh"

module tcu8_timer (
	// Clock and reset
	input  wire       i_clk,
	input  wire       i_rst_n,
	// Register port
	input  wire [3:0] i_addr,
	input  wire [7:0] i_wdata,
	input  wire       i_wr,
	input  wire       i_rd,
	output reg  [7:0] o_rdata,
	// Tick sources, one-cycle enables
	input  wire       i_io_tick,
	input  wire       i_xtal_tick,
	// Interrupt acknowledge, one-cycle pulses
	input  wire       i_ack_ovf,
	input  wire       i_ack_cmpa,
	input  wire       i_ack_cmpb,
	// Interrupt requests
	output reg        o_irq_ovf,
	output reg        o_irq_cmpa,
	output reg        o_irq_cmpb,
	// Waveform generator side
	output reg        o_match_a,
	output reg        o_match_b,
	output reg        o_top,
	output reg        o_max,
	output reg        o_bottom,
	output reg  [2:0] o_wave_mode,
	output reg  [1:0] o_cmp_mode_a,
	output reg  [1:0] o_cmp_mode_b,
	output reg        o_count_up
);
	reg  [7:0] ctrl_a_ff;
	reg  [7:0] ctrl_b_ff;
	reg  [7:0] count_ff;
	reg  [7:0] cmp_a_ff;
	reg  [7:0] cmp_b_ff;
	reg  [2:0] flags_ff;
	reg  [2:0] irq_en_ff;
	reg        async_ff;
	reg        up_ff;
	reg  [1:0] match_pend_ff;
	reg  [7:0] nxt_count;
	reg        nxt_up;
	reg  [2:0] nxt_flags;
	reg        ovf_evt;
	wire       tick;
	wire [1:0] match;
	wire [2:0] wgm;
	wire [7:0] top_val;
	wire       at_top;
	wire       at_bot;
	wire       dual_slope;
	wire       clear_on_top;
	wire       wr_cnt;

	assign wgm = {ctrl_b_ff[`TCU_CB_WGM2], ctrl_a_ff[`TCU_CA_WGM1], ctrl_a_ff[`TCU_CA_WGM0]};
	// Ceiling from compare A only in the CTC and "_A" variants
	assign top_val = (wgm == `TCU_WGM_CTC || wgm == `TCU_WGM_PCPWM_A || wgm == `TCU_WGM_FAST_A)
		? cmp_a_ff : `TCU_MAX;
	assign at_top       = (count_ff == top_val);
	assign at_bot       = (count_ff == `TCU_BOTTOM);
	assign dual_slope   = (wgm == `TCU_WGM_PCPWM) || (wgm == `TCU_WGM_PCPWM_A);
	assign clear_on_top = (wgm == `TCU_WGM_CTC) || (wgm == `TCU_WGM_FAST) || (wgm == `TCU_WGM_FAST_A);
	assign wr_cnt       = i_wr && (i_addr == `TCU_OFS_COUNT);

	tcu8_tick_sel u_tick (
		.i_clk       (i_clk),
		.i_rst_n     (i_rst_n),
		.i_async_sel (async_ff),
		.i_cs        (ctrl_b_ff[`TCU_CB_CS_HI:`TCU_CB_CS_LO]),
		.i_io_tick   (i_io_tick),
		.i_xtal_tick (i_xtal_tick),
		.o_tick      (tick)
	);

	tcu8_compare #(.W(8), .N(2)) u_cmp (
		.i_count (count_ff),
		.i_cmp   ({cmp_b_ff, cmp_a_ff}),
		.o_match (match)
	);

	// Count sequence
	always @* begin
		nxt_count = count_ff;
		nxt_up    = up_ff;
		ovf_evt   = 1'b0;
		if (wr_cnt) begin
			nxt_count = i_wdata;
		end else if (tick) begin
			if (dual_slope) begin
				if (up_ff && at_top) begin
					nxt_up    = 1'b0;
					nxt_count = count_ff - 8'h01;
				end else if (!up_ff && at_bot) begin
					nxt_up    = 1'b1;
					nxt_count = count_ff + 8'h01;
				end else if (up_ff) begin
					nxt_count = count_ff + 8'h01;
				end else begin
					nxt_count = count_ff - 8'h01;
				end
				ovf_evt = at_bot;
			end else if (clear_on_top && at_top) begin
				nxt_count = `TCU_BOTTOM;
				nxt_up    = 1'b1;
				ovf_evt   = (wgm != `TCU_WGM_CTC);
			end else begin
				nxt_count = count_ff + 8'h01;
				nxt_up    = 1'b1;
				ovf_evt   = (count_ff == `TCU_MAX);
			end
		end
	end

	// Flags: hardware set beats acknowledge and write-one clear
	always @* begin
		nxt_flags = flags_ff;
		if (i_ack_ovf)
			nxt_flags[`TCU_FL_OVF] = 1'b0;
		if (i_ack_cmpa)
			nxt_flags[`TCU_FL_CMPA] = 1'b0;
		if (i_ack_cmpb)
			nxt_flags[`TCU_FL_CMPB] = 1'b0;
		if (i_wr && i_addr == `TCU_OFS_FLAGS)
			nxt_flags = nxt_flags & ~i_wdata[2:0];
		if (ovf_evt)
			nxt_flags[`TCU_FL_OVF] = 1'b1;
		// A match still standing at the tick counts as well, so back-to-back ticks work
		if (tick && (match_pend_ff[0] || match[0]))
			nxt_flags[`TCU_FL_CMPA] = 1'b1;
		if (tick && (match_pend_ff[1] || match[1]))
			nxt_flags[`TCU_FL_CMPB] = 1'b1;
	end

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			ctrl_a_ff     <= `TCU_RST_BYTE;
			ctrl_b_ff     <= `TCU_RST_BYTE;
			count_ff      <= `TCU_RST_BYTE;
			cmp_a_ff      <= `TCU_RST_BYTE;
			cmp_b_ff      <= `TCU_RST_BYTE;
			flags_ff      <= 3'h0;
			irq_en_ff     <= 3'h0;
			async_ff      <= 1'b0;
			up_ff         <= 1'b1;
			match_pend_ff <= 2'h0;
		end else begin
			count_ff  <= nxt_count;
			up_ff     <= nxt_up;
			flags_ff  <= nxt_flags;
			// Match is latched until the next tick, then consumed, so an old count cannot set the flag twice
			if (tick)
				match_pend_ff <= 2'h0;
			else
				match_pend_ff <= match_pend_ff | match;
			if (i_wr) begin
				case (i_addr)
					`TCU_OFS_CTRL_A: ctrl_a_ff <= i_wdata;
					`TCU_OFS_CTRL_B: ctrl_b_ff <= i_wdata;
					`TCU_OFS_CMP_A:  cmp_a_ff  <= i_wdata;
					`TCU_OFS_CMP_B:  cmp_b_ff  <= i_wdata;
					`TCU_OFS_IRQ_EN: irq_en_ff <= i_wdata[2:0];
					`TCU_OFS_ASYNC:  async_ff  <= i_wdata[`TCU_AS_SEL];
					default: ;
				endcase
			end
		end
	end

	// Registered outputs
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_rdata      <= 8'h00;
			o_irq_ovf    <= 1'b0;
			o_irq_cmpa   <= 1'b0;
			o_irq_cmpb   <= 1'b0;
			o_match_a    <= 1'b0;
			o_match_b    <= 1'b0;
			o_top        <= 1'b0;
			o_max        <= 1'b0;
			o_bottom     <= 1'b0;
			o_wave_mode  <= 3'h0;
			o_cmp_mode_a <= 2'h0;
			o_cmp_mode_b <= 2'h0;
			o_count_up   <= 1'b1;
		end else begin
			o_irq_ovf    <= flags_ff[`TCU_FL_OVF] & irq_en_ff[`TCU_FL_OVF] & ~i_ack_ovf;
			o_irq_cmpa   <= flags_ff[`TCU_FL_CMPA] & irq_en_ff[`TCU_FL_CMPA] & ~i_ack_cmpa;
			o_irq_cmpb   <= flags_ff[`TCU_FL_CMPB] & irq_en_ff[`TCU_FL_CMPB] & ~i_ack_cmpb;
			o_match_a    <= match[0];
			o_match_b    <= match[1];
			o_top        <= at_top;
			o_max        <= (count_ff == `TCU_MAX);
			o_bottom     <= at_bot;
			o_wave_mode  <= wgm;
			// Mode zero is passed through as is; the generator treats it as no action
			o_cmp_mode_a <= ctrl_a_ff[`TCU_CA_COMA_HI:`TCU_CA_COMA_LO];
			o_cmp_mode_b <= ctrl_a_ff[`TCU_CA_COMB_HI:`TCU_CA_COMB_LO];
			o_count_up   <= up_ff;
			o_rdata      <= 8'h00;
			if (i_rd) begin
				case (i_addr)
					`TCU_OFS_CTRL_A: o_rdata <= ctrl_a_ff;
					`TCU_OFS_CTRL_B: o_rdata <= ctrl_b_ff;
					`TCU_OFS_COUNT:  o_rdata <= count_ff;
					`TCU_OFS_CMP_A:  o_rdata <= cmp_a_ff;
					`TCU_OFS_CMP_B:  o_rdata <= cmp_b_ff;
					`TCU_OFS_FLAGS:  o_rdata <= {5'h00, flags_ff};
					`TCU_OFS_IRQ_EN: o_rdata <= {5'h00, irq_en_ff};
					`TCU_OFS_ASYNC:  o_rdata <= {2'h0, async_ff, 5'h00};
					default:         o_rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule // tcu8_timer
`default_nettype wire

// >>> hw/tcu8_regs.vh
`ifndef TCU8_REGS_VH
`define TCU8_REGS_VH

`define TCU_ADDR_W      4
`define TCU_OFS_CTRL_A  4'h0
`define TCU_OFS_CTRL_B  4'h1
`define TCU_OFS_COUNT   4'h2
`define TCU_OFS_CMP_A   4'h3
`define TCU_OFS_CMP_B   4'h4
`define TCU_OFS_FLAGS   4'h5
`define TCU_OFS_IRQ_EN  4'h6
`define TCU_OFS_ASYNC   4'h7

// Control A: [7:6] output mode A, [5:4] output mode B, [1:0] waveform mode bits 1:0
`define TCU_CA_COMA_HI  7
`define TCU_CA_COMA_LO  6
`define TCU_CA_COMB_HI  5
`define TCU_CA_COMB_LO  4
`define TCU_CA_WGM1     1
`define TCU_CA_WGM0     0
// Control B: [3] waveform mode bit 2, [2:0] clock source select
`define TCU_CB_WGM2     3
`define TCU_CB_CS_HI    2
`define TCU_CB_CS_LO    0
// Flags and enables: [2] compare B, [1] compare A, [0] overflow
`define TCU_FL_CMPB     2
`define TCU_FL_CMPA     1
`define TCU_FL_OVF      0
`define TCU_AS_SEL      5

`define TCU_BOTTOM      8'h00
`define TCU_MAX         8'hff
`define TCU_RST_BYTE    8'h00

`define TCU_WGM_NORMAL  3'h0
`define TCU_WGM_PCPWM   3'h1
`define TCU_WGM_CTC     3'h2
`define TCU_WGM_FAST    3'h3
`define TCU_WGM_PCPWM_A 3'h5
`define TCU_WGM_FAST_A  3'h7

`endif

// >>> hw/tcu8_tick_sel.v
`timescale 1ns/1ps
`default_nettype none
`include "tcu8_regs.vh"

module tcu8_tick_sel (
	// Clock and reset
	input  wire       i_clk,
	input  wire       i_rst_n,
	// Selection
	input  wire       i_async_sel,
	input  wire [2:0] i_cs,
	// Tick sources
	input  wire       i_io_tick,
	input  wire       i_xtal_tick,
	// Result
	output reg        o_tick
);
	// Crystal tick arrives already aligned to i_clk, so a plain mux suffices
	wire src_tick = i_async_sel ? i_xtal_tick : i_io_tick;

	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_tick <= 1'b0;
		end else begin
			o_tick <= (i_cs != 3'h0) & src_tick;
		end
	end
endmodule // tcu8_tick_sel
`default_nettype wire

// >>> hw/tcu8_compare.v
`timescale 1ns/1ps
`default_nettype none

module tcu8_compare #(
	parameter W = 8,
	parameter N = 2
) (
	// Count and compare values
	input  wire [W-1:0]   i_count,
	input  wire [N*W-1:0] i_cmp,
	// Matches
	output wire [N-1:0]   o_match
);
	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : g_ch
			assign o_match[g] = (i_count == i_cmp[g*W +: W]);
		end
	endgenerate
endmodule // tcu8_compare
`default_nettype wire

// >>> testbench/tcu8_timer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module tcu8_timer_chk (
	// Clock, reset and register port
	input wire       i_clk,
	input wire       i_rst_n,
	input wire [3:0] i_addr,
	input wire [7:0] i_wdata,
	input wire       i_wr,
	input wire       i_rd,
	input wire [7:0] o_rdata,
	// Ticks, acknowledge and outputs
	input wire       i_io_tick,
	input wire       i_xtal_tick,
	input wire       i_ack_cmpa,
	input wire       o_irq_cmpa,
	input wire       o_max,
	input wire       o_bottom,
	input wire [2:0] o_wave_mode,
	input wire [1:0] o_cmp_mode_a
);
	reg [7:0] ca_ff;
	reg [7:0] cb_ff;
	reg [1:0] en_ff;
	reg [2:0] q_ff;
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			ca_ff <= 8'h00;
			cb_ff <= 8'h00;
			en_ff <= 2'h0;
		end else if (i_wr) begin
			ca_ff <= (i_addr == 4'h0) ? i_wdata : ca_ff;
			cb_ff <= (i_addr == 4'h1) ? i_wdata : cb_ff;
			en_ff <= (i_addr == 4'h6) ? i_wdata[1:0] : en_ff;
		end
	end
	// Ticks already in flight may land a few cycles after the source is cut
	always @(posedge i_clk) begin
		if (!i_rst_n || i_wr || cb_ff[2:0] != 3'h0)
			q_ff <= 3'h0;
		else if (q_ff != 3'h4)
			q_ff <= q_ff + 3'h1;
	end
	default clocking dcb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_cmp_wr; i_wr && i_addr == 4'h3; endsequence
	sequence s_cmp_rd; i_rd && i_addr == 4'h3; endsequence
	a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
		else $error("read data not idle");
	a_unmapped_zero: assert property (i_rd && i_addr[3] |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_cmp_readback: assert property (s_cmp_wr ##1 s_cmp_rd |=> o_rdata == $past(i_wdata, 2))
		else $error("compare value readback");
	a_mode_outputs: assert property ((!(i_wr && i_addr[3:1] == 3'h0)) [*2]
		|-> o_wave_mode == {cb_ff[3], ca_ff[1:0]} && o_cmp_mode_a == ca_ff[7:6]) else $error("mode outputs");
	a_stopped_hold: assert property (q_ff == 3'h4 |-> $stable(o_max) && $stable(o_bottom))
		else $error("count moved while stopped");
	a_ends_excl: assert property (!(o_max && o_bottom))
		else $error("max and bottom together");
	a_irq_mask: assert property ((!en_ff[1]) [*2] |-> !o_irq_cmpa)
		else $error("masked compare irq");
	a_ack_clear: assert property (i_ack_cmpa && !i_io_tick && !i_xtal_tick && !$past(i_io_tick)
		&& !$past(i_xtal_tick) |-> ##2 !o_irq_cmpa) else $error("ack left compare irq");
endmodule // tcu8_timer_chk
bind tcu8_timer tcu8_timer_chk chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_io_tick(i_io_tick), .i_xtal_tick(i_xtal_tick),
	.i_ack_cmpa(i_ack_cmpa), .o_irq_cmpa(o_irq_cmpa), .o_max(o_max), .o_bottom(o_bottom),
	.o_wave_mode(o_wave_mode), .o_cmp_mode_a(o_cmp_mode_a));
`default_nettype wire

// >>> testbench/tcu8_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module tcu8_timer_bench;
	logic       i_clk, i_rst_n, i_wr, i_rd, i_io_tick, i_xtal_tick, i_ack_ovf, i_ack_cmpa, i_ack_cmpb;
	logic [3:0] i_addr;
	logic [7:0] i_wdata, d;
	wire  [7:0] o_rdata;
	wire  [2:0] o_wave_mode;
	wire  [1:0] o_cmp_mode_a, o_cmp_mode_b;
	wire        o_irq_ovf, o_irq_cmpa, o_irq_cmpb, o_match_a, o_match_b, o_top, o_max, o_bottom, o_count_up;
	int         n_errors = 0, total_checks = 0;
	tcu8_timer dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .i_io_tick(i_io_tick), .i_xtal_tick(i_xtal_tick), .i_ack_ovf(i_ack_ovf),
		.i_ack_cmpa(i_ack_cmpa), .i_ack_cmpb(i_ack_cmpb), .o_irq_ovf(o_irq_ovf), .o_irq_cmpa(o_irq_cmpa),
		.o_irq_cmpb(o_irq_cmpb), .o_match_a(o_match_a), .o_match_b(o_match_b), .o_top(o_top), .o_max(o_max),
		.o_bottom(o_bottom), .o_wave_mode(o_wave_mode), .o_cmp_mode_a(o_cmp_mode_a),
		.o_cmp_mode_b(o_cmp_mode_b), .o_count_up(o_count_up));
	task automatic ck(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v, input bit rb);
		@(posedge i_clk);
		{i_wr, i_addr, i_wdata} <= {1'h1, a, v};
		@(posedge i_clk);
		i_wr <= 1'h0;
		i_rd <= rb;
		if (rb) begin
			@(posedge i_clk);
			i_rd <= 1'h0;
		end
		#1 d = o_rdata;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge i_clk);
		{i_rd, i_addr} <= {1'h1, a};
		@(posedge i_clk);
		i_rd <= 1'h0;
		#1 d = o_rdata;
	endtask
	// Source tick x=0 from the bus clock, x=1 from the crystal
	task automatic tk(input bit x, input int n);
		repeat (n) begin
			@(posedge i_clk);
			{i_xtal_tick, i_io_tick} <= x ? 2'h2 : 2'h1;
			@(posedge i_clk);
			{i_xtal_tick, i_io_tick} <= 2'h0;
			repeat (3) @(posedge i_clk);
			#1;
		end
	endtask
	task automatic ak(input logic [2:0] m);
		@(posedge i_clk);
		{i_ack_cmpb, i_ack_cmpa, i_ack_ovf} <= m;
		@(posedge i_clk);
		{i_ack_cmpb, i_ack_cmpa, i_ack_ovf} <= 3'h0;
		repeat (2) @(posedge i_clk);
		#1;
	endtask
	task automatic t_reset;
		for (int a = 0; a < 9; a++) begin
			rd(a[3:0]);
			ck("reset reg", 8'h00, d);
		end
		tk(0, 2);
		rd(4'h2);
		ck("stopped", 8'h00, d);
		wr(4'h2, 8'h5a, 1'b0);
		rd(4'h2);
		ck("cpu count", 8'h5a, d);
	endtask
	task automatic t_count;
		wr(4'h1, 8'h01, 1'b0);
		wr(4'h6, 8'h01, 1'b0);
		wr(4'h2, 8'hfe, 1'b0);
		tk(0, 1);
		ck("at max", 8'h02, {6'h00, o_max, o_bottom});
		tk(0, 1);
		rd(4'h2);
		ck("wrap", 8'h00, d);
		ck("at bottom", 8'h01, {6'h00, o_max, o_bottom});
		ck("ovf irq", 8'h01, {7'h00, o_irq_ovf});
		ak(3'h1);
		ck("ovf ack", 8'h00, {7'h00, o_irq_ovf});
	endtask
	task automatic t_async;
		wr(4'h7, 8'h20, 1'b0);
		wr(4'h2, 8'h30, 1'b0);
		tk(0, 1);
		tk(1, 1);
		rd(4'h2);
		ck("crystal", 8'h31, d);
		wr(4'h7, 8'h00, 1'b0);
		tk(1, 1);
		tk(0, 1);
		rd(4'h2);
		ck("bus clock", 8'h32, d);
	endtask
	task automatic t_wins;
		@(posedge i_clk);
		i_io_tick <= 1'h1;
		@(posedge i_clk);
		i_io_tick <= 1'h0;
		{i_wr, i_addr, i_wdata} <= {1'h1, 4'h2, 8'h80};
		@(posedge i_clk);
		i_wr <= 1'h0;
		rd(4'h2);
		ck("write wins", 8'h80, d);
	endtask
	task automatic t_cmp;
		wr(4'h3, 8'h10, 1'b1);
		ck("cmp a", 8'h10, d);
		wr(4'h4, 8'h12, 1'b0);
		wr(4'h6, 8'h06, 1'b0);
		wr(4'h2, 8'h0f, 1'b0);
		wr(4'h5, 8'h07, 1'b0);
		tk(0, 1);
		ck("match a", 8'h01, {7'h00, o_match_a});
		rd(4'h5);
		ck("flag early", 8'h00, d & 8'h06);
		tk(0, 1);
		rd(4'h5);
		ck("flag a", 8'h02, d & 8'h06);
		ck("irq a", 8'h01, {7'h00, o_irq_cmpa});
		wr(4'h5, 8'h00, 1'b0);
		rd(4'h5);
		ck("zero write", 8'h02, d & 8'h02);
		ak(3'h2);
		ck("ack a", 8'h00, {7'h00, o_irq_cmpa});
		tk(0, 2);
		ck("irq b", 8'h01, {7'h00, o_irq_cmpb});
		ck("no reflag a", 8'h00, {7'h00, o_irq_cmpa});
		wr(4'h5, 8'h04, 1'b0);
		rd(4'h5);
		ck("clear b", 8'h00, d & 8'h04);
	endtask
	task automatic t_ctc;
		wr(4'h0, 8'hd2, 1'b0);
		wr(4'h3, 8'h03, 1'b0);
		wr(4'h2, 8'h02, 1'b0);
		ck("modes", 8'hd2, {o_cmp_mode_a, o_cmp_mode_b, 1'h0, o_wave_mode});
		tk(0, 1);
		ck("top", 8'h01, {7'h00, o_top});
		tk(0, 1);
		rd(4'h2);
		ck("ceiling", 8'h00, d);
	endtask
	task automatic t_pwm;
		wr(4'h4, 8'h02, 1'b0);
		wr(4'h0, 8'h01, 1'b0);
		wr(4'h1, 8'h09, 1'b0);
		wr(4'h2, 8'h02, 1'b0);
		rd(4'h2);
		ck("match b", 8'h01, {7'h00, o_match_b});
		tk(0, 2);
		rd(4'h2);
		ck("pc down", 8'h02, d);
		ck("pc dir", 8'h00, {7'h00, o_count_up});
		tk(0, 2);
		ck("pc bottom", 8'h01, {7'h00, o_bottom});
		tk(0, 1);
		ck("pc up", 8'h01, {7'h00, o_count_up});
		rd(4'h5);
		ck("pc ovf", 8'h01, d & 8'h01);
		wr(4'h0, 8'h03, 1'b0);
		wr(4'h2, 8'h03, 1'b0);
		tk(0, 1);
		rd(4'h2);
		ck("fast wrap", 8'h00, d);
	endtask
	task automatic test_done;
		if (n_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		i_clk = 1'h0;
		forever #12.5 i_clk = ~i_clk;
	end
	initial begin
		repeat (20000) @(posedge i_clk);
		n_errors++;
		test_done;
	end
	initial begin
		{i_rst_n, i_wr, i_rd, i_io_tick, i_xtal_tick, i_ack_ovf, i_ack_cmpa, i_ack_cmpb} = 8'h00;
		{i_addr, i_wdata} = 12'h000;
		repeat (20) @(posedge i_clk);
		i_rst_n <= 1'h1;
		t_reset;
		t_count;
		t_async;
		t_wins;
		t_cmp;
		t_ctc;
		t_pwm;
		test_done;
	end
endmodule // tcu8_timer_bench
`default_nettype wire
